// file: src/wdt_pkg.sv
package wdt_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] CLEAR_IDX = 16'hFFFF;
  localparam logic [ADDR_W-1:0] CLEAR_ADDR = {CLEAR_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CFG_ADDR = 18'h00000;
  localparam logic [ADDR_W-1:0] CAUSE_ADDR = 18'h00004;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 18'h00008;
  localparam logic [ADDR_W-1:0] STATE_ADDR = 18'h0000C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_DISABLE_BIT = 0;
  localparam int CFG_RATE_BIT = 1;
  localparam int CFG_STOP_EN_BIT = 2;
  localparam int CAUSE_WDOG_BIT = 0;
  localparam int CAUSE_ILLOP_BIT = 1;
  localparam int CAUSE_W = 2;

  // ---------------------------------------------------------------
  // Reset values and cycle counts
  // ---------------------------------------------------------------
  localparam logic [2:0] CFG_RESET = 3'h4;
  localparam logic [CAUSE_W-1:0] MASK_RESET = 2'h0;
  localparam int PRE_W = 12;
  localparam int CNT_W = 6;
  localparam int SHORT_TAP = 7;
  localparam int KEEP_STAGES = 4;
  localparam int POR_CYCLES = 4096;
  localparam int RST_CYCLES = 64;
  localparam logic [12:0] POR_LAST = 13'(POR_CYCLES - 1);
  localparam logic [6:0] RST_LAST = 7'(RST_CYCLES - 1);

endpackage : wdt_pkg

// file: src/wdt_sync.sv
module wdt_sync
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_sync
);

  logic meta_q;

  // Only the second stage is read outside this module
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // wdt_sync

// file: src/wdt_chain.sv
module wdt_chain
#(
  parameter int PRE_W = 12,
  parameter int CNT_W = 6,
  parameter int SHORT_TAP = 7,
  parameter int KEEP_STAGES = 4
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clr_all,
  input wire logic i_clr_pre,
  input wire logic i_clr_upper,
  input wire logic i_hold,
  input wire logic i_short,
  output logic o_ovf,
  output logic [PRE_W-1:0] o_pre,
  output logic [CNT_W-1:0] o_cnt
);

  logic tick;

  // Short rate taps the low stages so the counter steps 2^(12-7) times faster
  assign tick = i_short ? (&o_pre[SHORT_TAP-1:0]) : (&o_pre);
  assign o_ovf = !i_hold && tick && (&o_cnt);

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      o_pre <= '0;
    else if (i_clr_all || i_clr_pre)
      o_pre <= '0;
    else if (i_clr_upper)
      o_pre <= {{(PRE_W-KEEP_STAGES){1'b0}}, o_pre[KEEP_STAGES-1:0] + 1'b1};
    else if (!i_hold)
      o_pre <= o_pre + 1'b1;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      o_cnt <= '0;
    else if (i_clr_all || i_clr_upper)
      o_cnt <= '0;
    else if (!i_hold && tick)
      o_cnt <= o_cnt + 1'b1;
  end

endmodule // wdt_chain

// file: src/wdt_top.sv
// Chosen here: register access over APB.
module wdt_top
#(
  parameter int PRE_W = wdt_pkg::PRE_W,
  parameter int CNT_W = wdt_pkg::CNT_W
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [wdt_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [7:0] i_vec_lo,
  input wire logic i_vec_fetch,
  input wire logic i_stop_exec,
  input wire logic i_stop_mode,
  input wire logic i_monitor_mode,
  input wire logic i_irq_pin_tst,
  output logic o_int_reset,
  output logic o_stop_allowed,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [2:0] cfg_q;
  logic [wdt_pkg::CAUSE_W-1:0] cause_q;
  logic [wdt_pkg::CAUSE_W-1:0] mask_q;
  logic [wdt_pkg::CAUSE_W-1:0] cause_set;
  logic [12:0] por_cnt_q;
  logic por_done_q;
  logic [6:0] rst_cnt_q;
  logic rst_active_q;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic tst_sync;
  logic wdog_off;
  logic ovf;
  logic illegal_stop;
  logic start_rst;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic mapped;
  logic clr_write;
  logic clr_pre;
  logic [PRE_W-1:0] pre;
  logic [CNT_W-1:0] cnt;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup_ph = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign wr_acc = access_ph && i_pwrite;
  assign mapped = (i_paddr == wdt_pkg::CFG_ADDR) || (i_paddr == wdt_pkg::CAUSE_ADDR) ||
                  (i_paddr == wdt_pkg::MASK_ADDR) || (i_paddr == wdt_pkg::STATE_ADDR) ||
                  (i_paddr == wdt_pkg::CLEAR_ADDR);
  // Zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign o_pslverr = access_ph && !mapped;
  assign o_prdata = prdata_q;
  assign clr_write = wr_acc && (i_paddr == wdt_pkg::CLEAR_ADDR);

  // ---------------------------------------------------------------
  // Pin input crossing
  // ---------------------------------------------------------------
  wdt_sync u_tst_sync
  (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_async(i_irq_pin_tst),
    .o_sync(tst_sync)
  );

  // ---------------------------------------------------------------
  // Enable and clear sources
  // ---------------------------------------------------------------
  // The watchdog is also frozen while its own reset pulse runs
  assign wdog_off = cfg_q[wdt_pkg::CFG_DISABLE_BIT] ||
                    (i_monitor_mode && tst_sync) ||
                    rst_active_q;
  assign illegal_stop = i_stop_exec && !cfg_q[wdt_pkg::CFG_STOP_EN_BIT];
  assign o_stop_allowed = cfg_q[wdt_pkg::CFG_STOP_EN_BIT];
  assign clr_pre = !por_done_q ||
                   i_vec_fetch ||
                   (i_stop_exec && !illegal_stop) ||
                   i_stop_mode;
  assign start_rst = (ovf || illegal_stop) && !rst_active_q;

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  // Wait mode is not an input: the chain simply keeps running in it
  wdt_chain
  #(
    .PRE_W(PRE_W),
    .CNT_W(CNT_W),
    .SHORT_TAP(wdt_pkg::SHORT_TAP),
    .KEEP_STAGES(wdt_pkg::KEEP_STAGES)
  )
  u_chain
  (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clr_all(rst_active_q),
    .i_clr_pre(clr_pre),
    .i_clr_upper(clr_write),
    .i_hold(wdog_off),
    .i_short(cfg_q[wdt_pkg::CFG_RATE_BIT]),
    .o_ovf(ovf),
    .o_pre(pre),
    .o_cnt(cnt)
  );

  // ---------------------------------------------------------------
  // Power-on prescaler hold
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
    end
    else if (!por_done_q)
    begin
      por_cnt_q <= por_cnt_q + 1'b1;
      por_done_q <= (por_cnt_q == wdt_pkg::POR_LAST);
    end
  end

  // ---------------------------------------------------------------
  // Internal reset pulse
  // ---------------------------------------------------------------
  // Overflow and illegal stop share one pulse; a second cause inside it is absorbed
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rst_active_q <= 1'b0;
      rst_cnt_q <= '0;
    end
    else if (start_rst)
    begin
      rst_active_q <= 1'b1;
      rst_cnt_q <= '0;
    end
    else if (rst_active_q)
    begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
      if (rst_cnt_q == wdt_pkg::RST_LAST)
        rst_active_q <= 1'b0;
    end
  end

  assign o_int_reset = rst_active_q;

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      cfg_q <= wdt_pkg::CFG_RESET;
    else if (rst_active_q)
      cfg_q[wdt_pkg::CFG_RATE_BIT] <= 1'b0;
    else if (wr_acc && (i_paddr == wdt_pkg::CFG_ADDR))
      cfg_q <= i_pwdata[2:0];
  end

  // ---------------------------------------------------------------
  // Reset cause flags and mask
  // ---------------------------------------------------------------
  // Flags survive the internal reset so software can read why it restarted
  assign cause_set[wdt_pkg::CAUSE_WDOG_BIT] = ovf && !rst_active_q;
  assign cause_set[wdt_pkg::CAUSE_ILLOP_BIT] = illegal_stop && !rst_active_q;

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      cause_q <= '0;
    else if (wr_acc && (i_paddr == wdt_pkg::CAUSE_ADDR))
      cause_q <= (cause_q & ~i_pwdata[wdt_pkg::CAUSE_W-1:0]) | cause_set;
    else
      cause_q <= cause_q | cause_set;
  end

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      mask_q <= wdt_pkg::MASK_RESET;
    else if (wr_acc && (i_paddr == wdt_pkg::MASK_ADDR))
      mask_q <= i_pwdata[wdt_pkg::CAUSE_W-1:0];
  end

  // Status-block line only; the watchdog itself requests no CPU interrupt
  assign o_irq = |(cause_q & mask_q);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_d = '0;
    case (i_paddr)
      wdt_pkg::CFG_ADDR: rdata_d[2:0] = cfg_q;
      wdt_pkg::CAUSE_ADDR: rdata_d[wdt_pkg::CAUSE_W-1:0] = cause_q;
      wdt_pkg::MASK_ADDR: rdata_d[wdt_pkg::CAUSE_W-1:0] = mask_q;
      wdt_pkg::STATE_ADDR: rdata_d = {5'h00, por_done_q, wdog_off, rst_active_q,
                                      2'h0, cnt, 4'h0, pre};
      wdt_pkg::CLEAR_ADDR: rdata_d[7:0] = i_vec_lo;
      default: rdata_d = '0;
    endcase
  end

  // Captured in the setup cycle so the access cycle sees a flop output
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      prdata_q <= '0;
    else if (setup_ph && !i_pwrite)
      prdata_q <= rdata_d;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_overflow;
    ovf && !rst_active_q;
  endsequence

  sequence s_pulse_end;
    rst_active_q && (rst_cnt_q == wdt_pkg::RST_LAST);
  endsequence

  sequence s_live_tick;
    (&pre) && !wdog_off && !clr_write;
  endsequence

  sequence s_short_tick;
    cfg_q[wdt_pkg::CFG_RATE_BIT] && (&pre[wdt_pkg::SHORT_TAP-1:0]) && !wdog_off &&
    !clr_write;
  endsequence

  sequence s_bad_stop;
    illegal_stop && !rst_active_q;
  endsequence

  sequence s_monitor_off;
    i_monitor_mode && tst_sync && !clr_write && !rst_active_q;
  endsequence

  a_overflow_reset: assert property (s_overflow |=> o_int_reset && rst_cnt_q == 7'h00)
    else $error("overflow did not start the internal reset");

  a_reset_width: assert property (s_pulse_end |=> !o_int_reset)
    else $error("internal reset did not end after 64 cycles");

  a_reset_hold: assert property ($rose(o_int_reset) |-> o_int_reset [*8])
    else $error("internal reset dropped early");

  a_cause_flag: assert property (s_overflow |=> cause_q[wdt_pkg::CAUSE_WDOG_BIT])
    else $error("watchdog cause flag not set on overflow");

  a_clear_write: assert property (clr_write && !rst_active_q && !clr_pre
                                  |=> cnt == '0 && pre[PRE_W-1:wdt_pkg::KEEP_STAGES] == '0)
    else $error("clear write did not clear counter and upper prescaler");

  a_clear_low_run: assert property (clr_write && !clr_pre && !rst_active_q
                                    |=> pre[3:0] == $past(pre[3:0]) + 4'h1)
    else $error("low prescaler stages stopped on a clear write");

  a_vector_read: assert property (access_ph && !i_pwrite && i_paddr == wdt_pkg::CLEAR_ADDR
                                  |-> o_prdata == {24'h000000, $past(i_vec_lo)})
    else $error("clear register read did not return vector low byte");

  a_disable_hold: assert property (wdog_off && !clr_write && !rst_active_q
                                   |=> $stable(cnt) && !ovf)
    else $error("disabled watchdog kept counting");

  a_stop_hold: assert property (i_stop_mode |=> pre == '0)
    else $error("prescaler ran during stop mode");

  a_illegal_stop: assert property (s_bad_stop |=> o_int_reset)
    else $error("disabled stop instruction did not reset");

  a_rate_cleared: assert property (o_int_reset |=> !cfg_q[wdt_pkg::CFG_RATE_BIT])
    else $error("rate select survived an internal reset");

  a_power_on_hold: assert property (!por_done_q |=> pre == '0)
    else $error("prescaler ran before the power-on delay ended");

  a_internal_clear: assert property (o_int_reset |=> cnt == '0 && pre == '0)
    else $error("internal reset did not clear the chain");

  a_count_step: assert property (s_live_tick |=> cnt == CNT_W'($past(cnt) + 1'b1))
    else $error("counter did not step on a full prescaler");

  a_short_step: assert property (s_short_tick |=> cnt != $past(cnt))
    else $error("short rate did not step the counter");

  a_cause_illop: assert property (s_bad_stop |=> cause_q[wdt_pkg::CAUSE_ILLOP_BIT])
    else $error("illegal stop cause flag not set");

  a_fetch_clear: assert property (i_vec_fetch |=> pre == '0)
    else $error("vector fetch did not clear the prescaler");

  a_stop_clear: assert property (i_stop_exec && o_stop_allowed |=> pre == '0)
    else $error("stop instruction did not clear the prescaler");

  a_monitor_hold: assert property (s_monitor_off |=> $stable(cnt))
    else $error("watchdog counted in monitor mode at test voltage");

  a_por_length: assert property (por_cnt_q == wdt_pkg::POR_LAST |=> por_done_q)
    else $error("power-on delay did not end after 4096 cycles");

  a_por_early: assert property (por_cnt_q < wdt_pkg::POR_LAST |=> !por_done_q)
    else $error("power-on delay ended early");

  a_stray_reset: assert property ($rose(o_int_reset) |-> $past(start_rst))
    else $error("internal reset started without a cause");

endmodule // wdt_top

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [wdt_pkg::ADDR_W-1:0] i_paddr = '0;
  logic [31:0] i_pwdata = 32'h0;
  logic [7:0] i_vec_lo = 8'hA5;
  logic i_vec_fetch = 1'b0;
  logic i_stop_exec = 1'b0;
  logic i_stop_mode = 1'b0;
  logic i_monitor_mode = 1'b0;
  logic i_irq_pin_tst = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_int_reset;
  logic o_stop_allowed;
  logic o_irq;
  logic err;
  logic [31:0] rd;
  int fail_count = 0;
  int checks = 0;
  int c;

  always #2.5 i_sys_clk = ~i_sys_clk;

  wdt_top wdt_top_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_vec_lo(i_vec_lo),
    .i_vec_fetch(i_vec_fetch), .i_stop_exec(i_stop_exec), .i_stop_mode(i_stop_mode),
    .i_monitor_mode(i_monitor_mode), .i_irq_pin_tst(i_irq_pin_tst),
    .o_int_reset(o_int_reset), .o_stop_allowed(o_stop_allowed), .o_irq(o_irq));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [wdt_pkg::ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1)
    begin
      @(posedge i_sys_clk);
    end
    q = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // Cycles until the internal reset is seen, capped at lim
  task automatic wait_rst(input int lim, output int n);
    n = 0;
    while (o_int_reset !== 1'b1 && n < lim)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic pulse_len(output int n);
    n = 0;
    while (o_int_reset === 1'b1 && n < 200)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic strobe(input int which);
    @(posedge i_sys_clk);
    if (which == 0) i_vec_fetch <= 1'b1;
    else i_stop_exec <= 1'b1;
    @(posedge i_sys_clk);
    i_vec_fetch <= 1'b0;
    i_stop_exec <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // Longest path is a few timeouts of 2^13 cycles plus the power-on delay
  initial
  begin
    repeat (80000) @(posedge i_sys_clk);
    fail_count++;
    $display("CHECK FAILED run expected finish seen timeout");
    report_and_stop();
  end

  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("pre_held", 32'h0, {20'h0, rd[11:0]});
    apb(0, wdt_pkg::CFG_ADDR, 0, rd);
    chk("cfg_reset", 32'h4, rd);
    apb(0, wdt_pkg::MASK_ADDR, 0, rd);
    chk("mask_reset", 32'h0, rd);
    apb(0, wdt_pkg::CLEAR_ADDR, 0, rd);
    chk("vec_lo", 32'hA5, rd);
    apb(0, 18'h00010, 0, rd);
    chk("unmapped", 32'h1, {rd[30:0], err});
    chk("stop_allowed", 32'h1, 32'(o_stop_allowed));
    chk("pready", 32'h1, 32'(o_pready));
    repeat (4200) @(posedge i_sys_clk);
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("por_done", 32'h1, 32'(rd[26]));
    $display("test reset_values done");

    apb(1, wdt_pkg::CFG_ADDR, 32'h6, rd);
    apb(1, wdt_pkg::CLEAR_ADDR, 32'h5A, rd);
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("clr_upper", 32'h1, 32'(rd[21:16] == 6'h00 && rd[11:0] < 12'h012));
    apb(1, wdt_pkg::CLEAR_ADDR, 32'hFF, rd);
    wait_rst(9000, c);
    chk("short_timeout", 32'h1, 32'(c >= 8170 && c <= 8200));
    pulse_len(c);
    chk("pulse_len", 32'(wdt_pkg::RST_CYCLES), 32'(c));
    apb(0, wdt_pkg::CAUSE_ADDR, 0, rd);
    chk("cause_wdog", 32'h1, rd);
    apb(0, wdt_pkg::CFG_ADDR, 0, rd);
    chk("rate_cleared", 32'h4, rd);
    chk("no_irq", 32'h0, 32'(o_irq));
    $display("test timeout done");

    apb(1, wdt_pkg::CFG_ADDR, 32'h7, rd);
    apb(1, wdt_pkg::CLEAR_ADDR, 32'h0, rd);
    wait_rst(9000, c);
    chk("disabled", 32'd9000, 32'(c));
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("cnt_held", 32'h0, 32'(rd[21:16]));
    apb(1, wdt_pkg::CFG_ADDR, 32'h6, rd);
    wait_rst(9000, c);
    chk("reenabled", 32'h1, 32'(c <= 8200));
    pulse_len(c);
    $display("test disable done");

    apb(1, wdt_pkg::CFG_ADDR, 32'h6, rd);
    i_monitor_mode <= 1'b1;
    i_irq_pin_tst <= 1'b1;
    apb(1, wdt_pkg::CLEAR_ADDR, 32'h0, rd);
    wait_rst(9000, c);
    chk("monitor_off", 32'd9000, 32'(c));
    @(posedge i_sys_clk);
    i_monitor_mode <= 1'b0;
    wait_rst(9000, c);
    chk("monitor_left", 32'h1, 32'(c <= 8200));
    pulse_len(c);
    $display("test monitor done");

    apb(1, wdt_pkg::CLEAR_ADDR, 32'h0, rd);
    i_stop_mode <= 1'b1;
    repeat (50) @(posedge i_sys_clk);
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("stop_hold", 32'h0, 32'(rd[11:0]));
    i_stop_mode <= 1'b0;
    repeat (40) @(posedge i_sys_clk);
    strobe(0);
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("fetch_clr", 32'h1, 32'(rd[11:0] < 12'h010));
    repeat (40) @(posedge i_sys_clk);
    strobe(1);
    apb(0, wdt_pkg::STATE_ADDR, 0, rd);
    chk("stop_clr", 32'h1, 32'(rd[11:0] < 12'h010));
    chk("legal_stop", 32'h0, 32'(o_int_reset));
    $display("test stop done");

    apb(1, wdt_pkg::CFG_ADDR, 32'h0, rd);
    #1;
    chk("stop_denied", 32'h0, 32'(o_stop_allowed));
    strobe(1);
    #1;
    wait_rst(5, c);
    chk("illegal_stop", 32'h1, 32'(c <= 2));
    pulse_len(c);
    apb(0, wdt_pkg::CAUSE_ADDR, 0, rd);
    chk("cause_both", 32'h3, rd);
    $display("test illegal_stop done");

    // Interrupt path: mask, raise, clear by writing one
    apb(1, wdt_pkg::MASK_ADDR, 32'h2, rd);
    #1;
    chk("irq_masked_in", 32'h1, 32'(o_irq));
    apb(1, wdt_pkg::CAUSE_ADDR, 32'h2, rd);
    #1;
    chk("irq_cleared", 32'h0, 32'(o_irq));
    apb(0, wdt_pkg::CAUSE_ADDR, 0, rd);
    chk("cause_w1c", 32'h1, rd);
    apb(1, wdt_pkg::MASK_ADDR, 32'h1, rd);
    #1;
    chk("irq_wdog", 32'h1, 32'(o_irq));
    apb(1, wdt_pkg::CAUSE_ADDR, 32'h1, rd);
    #1;
    chk("irq_off", 32'h0, 32'(o_irq));
    $display("test interrupt done");
    report_and_stop();
  end
endmodule // tb_top
